// >>> logic/pad_decoder.v
// Peripheral and global memory address decoder with part identification
`timescale 1ns/100ps
`default_nettype none
`include "pad_map.vh"

module pad_decoder #(
	// Part identification fields (values arbitrary)
	parameter [3:0] ID_MAJOR_FAMILY = 4'h5,
	parameter [5:0] ID_MINOR_FAMILY = 6'h0A,
	parameter [1:0] ID_MAJOR_MASK = 2'h1,
	parameter [3:0] ID_MINOR_MASK = 4'h3,
	// Version word of the information row (value arbitrary)
	parameter [15:0] VERSION_WORD = 16'h0000,
	// Derivative memory parameters, largest part by default
	parameter [22:0] FLASH_LOW = 23'h7C0000,
	parameter [22:0] RAM_LOW = 23'h0FD000,
	parameter [22:0] DATA_FLASH_TOP = 23'h101FFF
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Access port from the bus masters
	input wire [`PAD_AW-1:0] bus_addr,
	input wire [`PAD_DW-1:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output wire [`PAD_DW-1:0] bus_rdata,
	// Forwarded register access to peripheral modules
	output wire [`PAD_NMOD-1:0] mod_sel,
	output wire mod_wr,
	output wire mod_rd,
	output wire [`PAD_OW-1:0] mod_addr,
	output wire [`PAD_DW-1:0] mod_wdata,
	// Forwarded memory access
	output wire [2:0] mem_sel,
	output wire [8:0] mem_page,
	output wire [13:0] mem_off,
	// Illegal address reset request
	output wire illegal_rst
);

	// Inclusive range check on a global address
	function in_rng;
		input [`PAD_AW-1:0] a;
		input [`PAD_AW-1:0] lo;
		input [`PAD_AW-1:0] hi;
		begin
			in_rng = (a >= lo) && (a <= hi);
		end
	endfunction

	// Assembled part identification word
	wire [15:0] part_id;
	// Any access this cycle
	wire acc;
	// Combinational module hits
	reg [`PAD_NMOD-1:0] hit;
	// Combinational memory hits
	reg [2:0] mhit;
	// Location answered by the decoder itself
	reg own_hit;
	// Reserved register or undefined range
	reg rsv_hit;
	// Offsets into the memory arrays
	wire [`PAD_AW-1:0] pf_diff;
	wire [`PAD_AW-1:0] ram_diff;
	wire [`PAD_AW-1:0] df_diff;
	// Next values of the flops
	reg [8:0] page_next;
	reg [13:0] off_next;
	reg [`PAD_DW-1:0] rdata_next;
	// Output flops
	reg [`PAD_NMOD-1:0] sel_reg;
	reg wr_reg;
	reg rd_reg;
	reg [`PAD_OW-1:0] addr_reg;
	reg [`PAD_DW-1:0] wdata_reg;
	reg [2:0] msel_reg;
	reg [8:0] page_reg;
	reg [13:0] off_reg;
	reg [`PAD_DW-1:0] rdata_reg;
	reg illegal_reg;

	// Fixed part identification layout
	assign part_id = {ID_MAJOR_FAMILY, ID_MINOR_FAMILY,
		ID_MAJOR_MASK, ID_MINOR_MASK};

	// One strobe at a time from the master
	assign acc = bus_wr | bus_rd;

	// Distances from each array base
	assign pf_diff = bus_addr - FLASH_LOW;
	assign ram_diff = bus_addr - RAM_LOW;
	assign df_diff = bus_addr - `PAD_DF_LO;

	// Register space decode; windows are disjoint so one bit at most
	always @* begin
		hit = `PAD_SEL_RST;
		hit[`PAD_M_PORT] = in_rng(bus_addr, `PAD_PORT_A_LO, `PAD_PORT_A_HI)
			| in_rng(bus_addr, `PAD_PORT_B_LO, `PAD_PORT_B_HI)
			| in_rng(bus_addr, `PAD_PORT_C_LO, `PAD_PORT_C_HI);
		hit[`PAD_M_PORT] = hit[`PAD_M_PORT]
			| in_rng(bus_addr, `PAD_PORT_D_LO, `PAD_PORT_D_HI)
			| in_rng(bus_addr, `PAD_PORT_E_LO, `PAD_PORT_E_HI);
		hit[`PAD_M_MMU] = in_rng(bus_addr, `PAD_MMU_A_LO, `PAD_MMU_A_HI)
			| in_rng(bus_addr, `PAD_MMU_B_LO, `PAD_MMU_B_HI);
		hit[`PAD_M_DBG] = in_rng(bus_addr, `PAD_DBG_LO, `PAD_DBG_HI);
		hit[`PAD_M_CRU] = in_rng(bus_addr, `PAD_CRU_LO, `PAD_CRU_HI);
		hit[`PAD_M_CTM] = in_rng(bus_addr, `PAD_CTM_LO, `PAD_CTM_HI);
		hit[`PAD_M_SL0] = in_rng(bus_addr, `PAD_SL0_LO, `PAD_SL0_HI);
		hit[`PAD_M_SL1] = in_rng(bus_addr, `PAD_SL1_LO, `PAD_SL1_HI);
		hit[`PAD_M_SPP] = in_rng(bus_addr, `PAD_SPP_LO, `PAD_SPP_HI);
		hit[`PAD_M_FLC] = in_rng(bus_addr, `PAD_FLC_LO, `PAD_FLC_HI);
		hit[`PAD_M_INT] = in_rng(bus_addr, `PAD_INT_LO, `PAD_INT_HI);
		hit[`PAD_M_CAN] = in_rng(bus_addr, `PAD_CAN_LO, `PAD_CAN_HI);
		hit[`PAD_M_ADC] = in_rng(bus_addr, `PAD_ADC_LO, `PAD_ADC_HI);
		hit[`PAD_M_VRG] = in_rng(bus_addr, `PAD_VRG_LO, `PAD_VRG_HI);
		hit[`PAD_M_PWM] = in_rng(bus_addr, `PAD_PWM_LO, `PAD_PWM_HI);
		hit[`PAD_M_PIT] = in_rng(bus_addr, `PAD_PIT_LO, `PAD_PIT_HI);
	end

	// Memory window decode and page split
	always @* begin
		mhit = `PAD_MEM_RST;
		page_next = `PAD_PAGE_RST;
		off_next = `PAD_OFF_RST;
		// Data flash: only the implemented part of its window
		if (in_rng(bus_addr, `PAD_DF_LO, DATA_FLASH_TOP)) begin
			mhit[`PAD_S_DF] = 1'b1;
			page_next = {1'b0, df_diff[`PAD_DF_SHIFT+7:`PAD_DF_SHIFT]};
			off_next = {4'h0, df_diff[`PAD_DF_SHIFT-1:0]};
		end
		// RAM from its base up to the top of the low megabyte
		else if (in_rng(bus_addr, RAM_LOW, `PAD_RAM_HI)) begin
			mhit[`PAD_S_RAM] = 1'b1;
			page_next = {1'b0, ram_diff[`PAD_RAM_SHIFT+7:`PAD_RAM_SHIFT]};
			off_next = {2'h0, ram_diff[`PAD_RAM_SHIFT-1:0]};
		end
		// Program flash from its base to the top of the map
		else if (in_rng(bus_addr, FLASH_LOW, `PAD_PF_HI)) begin
			mhit[`PAD_S_PF] = 1'b1;
			page_next = pf_diff[`PAD_PF_SHIFT+8:`PAD_PF_SHIFT];
			off_next = pf_diff[`PAD_PF_SHIFT-1:0];
		end
		// No memory hit
		else begin
			mhit = `PAD_MEM_RST;
		end
	end

	// Locations the decoder answers or silently absorbs
	always @* begin
		own_hit = in_rng(bus_addr, `PAD_PART_ID_HIGH, `PAD_PART_ID_LOW)
			| in_rng(bus_addr, `PAD_VER_HI, `PAD_VER_LO);
		// Reserved register space: low 2K minus anything implemented
		rsv_hit = (bus_addr <= `PAD_REGS_HI) && !(|hit) && !own_hit;
		// Undefined range counts as known, not as unimplemented
		rsv_hit = rsv_hit
			| in_rng(bus_addr, `PAD_UNDEF_LO, `PAD_UNDEF_HI);
	end

	// Read data of the decoder's own locations
	always @* begin
		case (bus_addr)
			// Part identification, writes have no path here
			`PAD_PART_ID_HIGH: begin
				rdata_next = part_id[15:8];
			end
			`PAD_PART_ID_LOW: begin
				rdata_next = part_id[7:0];
			end
			// Information row version word, high byte first
			`PAD_VER_HI: begin
				rdata_next = VERSION_WORD[15:8];
			end
			`PAD_VER_LO: begin
				rdata_next = VERSION_WORD[7:0];
			end
			// Reserved and routed locations read zero here
			default: begin
				rdata_next = `PAD_DAT_RST;
			end
		endcase
	end

	// Output registers; selects only ever for an actual access
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sel_reg <= `PAD_SEL_RST;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= `PAD_ADDR_RST;
			wdata_reg <= `PAD_DAT_RST;
			msel_reg <= `PAD_MEM_RST;
			page_reg <= `PAD_PAGE_RST;
			off_reg <= `PAD_OFF_RST;
			rdata_reg <= `PAD_DAT_RST;
			illegal_reg <= 1'b0;
		end else begin
			// Reserved hits leave every select low
			sel_reg <= acc ? hit : `PAD_SEL_RST;
			msel_reg <= acc ? mhit : `PAD_MEM_RST;
			// Strobes forwarded only with a select beside them
			wr_reg <= bus_wr & ((|hit) | (|mhit));
			rd_reg <= bus_rd & ((|hit) | (|mhit));
			// Address and data follow every access
			if (acc) begin
				addr_reg <= bus_addr[`PAD_OW-1:0];
				wdata_reg <= bus_wdata;
				page_reg <= page_next;
				off_reg <= off_next;
			end
			// Read data valid only in the cycle after the read
			rdata_reg <= bus_rd ? rdata_next : `PAD_DAT_RST;
			// Nothing owns the address: one-cycle reset request
			illegal_reg <= acc && !(|hit) && !(|mhit)
				&& !own_hit && !rsv_hit;
		end
	end

	// Outputs straight from flops
	assign bus_rdata = rdata_reg;
	assign mod_sel = sel_reg;
	assign mod_wr = wr_reg;
	assign mod_rd = rd_reg;
	assign mod_addr = addr_reg;
	assign mod_wdata = wdata_reg;
	assign mem_sel = msel_reg;
	assign mem_page = page_reg;
	assign mem_off = off_reg;
	assign illegal_rst = illegal_reg;

endmodule

`default_nettype wire

// >>> inc/pad_map.vh
// Address map, field layout and reset constants of the peripheral address decoder
// How it works
// - Port routing at 0000-0009, 000C-000D, 001C-001F
// - Port routing also at 0032-0033, 0240-027F
// - Memory mapping unit at 000A-000B, 0010-0017
// - Debug 0020-002F, clock/reset 0034-003F
// - Capture timer at 0040-006F
// - Serial units and SPI eight bytes each
// - Flash ctl, interrupt unit, CAN windows
// - Analog converter and regulator windows
// - PWM and periodic timer forty-byte windows
// - Reserved register writes change nothing
// - Reserved register reads return zero
// - Range 0C00-0FFF data undefined, unchecked
// - Unimplemented access raises illegal-address reset
// - Global 100000 up to DATA_FLASH_TOP is data flash
// - Program flash in 16K pages
// - RAM in 4K pages
// - Data flash in 1K pages
// - Part ID read-only at 001A, 001B
// - Part ID field layout 4/6/2/4 bits
// - Version word at global 4000E8
`ifndef PAD_MAP_VH
`define PAD_MAP_VH

// Widths of the bus
`define PAD_AW 23
`define PAD_DW 8
`define PAD_OW 11
`define PAD_NMOD 15

// Module select bit positions
`define PAD_M_PORT 0
`define PAD_M_MMU 1
`define PAD_M_DBG 2
`define PAD_M_CRU 3
`define PAD_M_CTM 4
`define PAD_M_SL0 5
`define PAD_M_SL1 6
`define PAD_M_SPP 7
`define PAD_M_FLC 8
`define PAD_M_INT 9
`define PAD_M_CAN 10
`define PAD_M_ADC 11
`define PAD_M_VRG 12
`define PAD_M_PWM 13
`define PAD_M_PIT 14

// Register space window bounds
`define PAD_PORT_A_LO 23'h000000
`define PAD_PORT_A_HI 23'h000009
`define PAD_MMU_A_LO 23'h00000A
`define PAD_MMU_A_HI 23'h00000B
`define PAD_PORT_B_LO 23'h00000C
`define PAD_PORT_B_HI 23'h00000D
`define PAD_MMU_B_LO 23'h000010
`define PAD_MMU_B_HI 23'h000017
`define PAD_PART_ID_HIGH 23'h00001A
`define PAD_PART_ID_LOW 23'h00001B
`define PAD_PORT_C_LO 23'h00001C
`define PAD_PORT_C_HI 23'h00001F
`define PAD_DBG_LO 23'h000020
`define PAD_DBG_HI 23'h00002F
`define PAD_PORT_D_LO 23'h000032
`define PAD_PORT_D_HI 23'h000033
`define PAD_CRU_LO 23'h000034
`define PAD_CRU_HI 23'h00003F
`define PAD_CTM_LO 23'h000040
`define PAD_CTM_HI 23'h00006F
`define PAD_SL0_LO 23'h0000C8
`define PAD_SL0_HI 23'h0000CF
`define PAD_SL1_LO 23'h0000D0
`define PAD_SL1_HI 23'h0000D7
`define PAD_SPP_LO 23'h0000D8
`define PAD_SPP_HI 23'h0000DF
`define PAD_FLC_LO 23'h000100
`define PAD_FLC_HI 23'h000113
`define PAD_INT_LO 23'h000120
`define PAD_INT_HI 23'h00012F
`define PAD_CAN_LO 23'h000140
`define PAD_CAN_HI 23'h00017F
`define PAD_PORT_E_LO 23'h000240
`define PAD_PORT_E_HI 23'h00027F
`define PAD_ADC_LO 23'h0002C0
`define PAD_ADC_HI 23'h0002EF
`define PAD_VRG_LO 23'h0002F0
`define PAD_VRG_HI 23'h0002F7
`define PAD_PWM_LO 23'h000300
`define PAD_PWM_HI 23'h000327
`define PAD_PIT_LO 23'h000340
`define PAD_PIT_HI 23'h000367
`define PAD_REGS_HI 23'h0007FF
`define PAD_UNDEF_LO 23'h000C00
`define PAD_UNDEF_HI 23'h000FFF

// Global memory windows
`define PAD_RAM_HI 23'h0FFFFF
`define PAD_DF_LO 23'h100000
`define PAD_DF_WIN_HI 23'h13FFFF
`define PAD_PF_HI 23'h7FFFFF
`define PAD_VER_HI 23'h4000E8
`define PAD_VER_LO 23'h4000E9

// Page shifts: 16K, 4K and 1K pages
`define PAD_PF_SHIFT 14
`define PAD_RAM_SHIFT 12
`define PAD_DF_SHIFT 10

// Memory select bit positions
`define PAD_S_PF 0
`define PAD_S_RAM 1
`define PAD_S_DF 2

// Reset values
`define PAD_SEL_RST 15'h0000
`define PAD_MEM_RST 3'h0
`define PAD_DAT_RST 8'h00
`define PAD_PAGE_RST 9'h000
`define PAD_OFF_RST 14'h0000
`define PAD_ADDR_RST 11'h000

`endif

// >>> tb/pad_decoder_checker.sv
// Concurrent checks on the address decoder ports
`timescale 1ns/100ps
`default_nettype none
module pad_decoder_checker #(
	parameter [22:0] DATA_FLASH_TOP = 23'h101FFF
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Access port
	input wire [22:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_rdata,
	// Forwarded access
	input wire [14:0] mod_sel,
	input wire mod_wr,
	input wire [2:0] mem_sel,
	input wire illegal_rst
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Any strobe taken
	wire acc = bus_wr | bus_rd;
	// Reserved register span
	wire rsv = (bus_addr >= 23'h000368) && (bus_addr <= 23'h0007FF);
	one_select_a: assert property ($onehot0(mod_sel)) else $error("several selects");
	port_route_a: assert property (acc && bus_addr >= 23'h000240 && bus_addr <= 23'h00027F
		|=> mod_sel == 15'h0001) else $error("port window select wrong");
	mmu_route_a: assert property (acc && bus_addr >= 23'h000010 && bus_addr <= 23'h000017
		|=> mod_sel == 15'h0002) else $error("mapping window select wrong");
	timer_route_a: assert property (bus_wr && bus_addr >= 23'h000040 && bus_addr <= 23'h00006F
		|=> mod_sel == 15'h0010 && mod_wr) else $error("timer write not routed");
	rsv_write_a: assert property (bus_wr && rsv
		|=> mod_sel == 15'h0000 && !mod_wr && !illegal_rst) else $error("reserved write acted");
	rsv_read_a: assert property (bus_rd && rsv |-> ##1 bus_rdata == 8'h00)
		else $error("reserved read not zero");
	illegal_hit_a: assert property (acc && bus_addr >= 23'h000800 && bus_addr <= 23'h000BFF
		|=> illegal_rst && mem_sel == 3'h0) else $error("no illegal reset");
	data_flash_map_a: assert property (acc && bus_addr >= 23'h100000 && bus_addr <= DATA_FLASH_TOP
		|=> mem_sel == 3'h4 && mod_sel == 15'h0000) else $error("data flash not mapped");
	id_write_a: assert property (bus_wr && bus_addr[22:1] == 22'h00000D
		|=> !illegal_rst && !mod_wr) else $error("id write acted");
	cover property (bus_wr ##1 mod_wr);
	cover property (illegal_rst);
	cover property (mem_sel != 3'h0);
endmodule
bind pad_decoder pad_decoder_checker #(.DATA_FLASH_TOP(DATA_FLASH_TOP)) u_chk (.core_clk(core_clk),
	.rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.mod_sel(mod_sel), .mod_wr(mod_wr), .mem_sel(mem_sel), .illegal_rst(illegal_rst));
`default_nettype wire

// >>> tb/pad_bus_master.sv
// Bus master model driving the decoder access port
`timescale 1ns/100ps
`default_nettype none
module pad_bus_master (
	// Clock
	input wire core_clk,
	// Access port toward the decoder
	output logic [22:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_wr,
	output logic bus_rd,
	// Read data back
	input wire [7:0] bus_rdata
);
	// Idle bus at time zero
	initial begin
		bus_addr = 23'h000000;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	// One-cycle write; released lines carry the inverse so stale values never pass
	task automatic wr(input logic [22:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
		bus_addr <= ~a;
		bus_wdata <= ~d;
		#1;
	endtask
	// One-cycle read; data taken in the single cycle it stands
	task automatic rd(input logic [22:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		bus_addr <= ~a;
		#1;
		d = bus_rdata;
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the peripheral address decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// Clock, reset and design wiring
	logic core_clk;
	logic rst;
	wire [22:0] bus_addr;
	wire [7:0] bus_wdata, bus_rdata, mod_wdata;
	wire bus_wr, bus_rd, mod_wr, mod_rd, illegal_rst;
	wire [14:0] mod_sel;
	wire [10:0] mod_addr;
	wire [2:0] mem_sel;
	wire [8:0] mem_page;
	wire [13:0] mem_off;
	int n_errors = 0;
	int checked = 0;
	logic [7:0] d;
	// Expected identification (arbitrary values)
	localparam [15:0] PID = {4'h5, 6'h0A, 2'h1, 4'h3};
	// Window bounds and their select bit
	logic [11:0] lo [20] = '{12'h000, 12'h00C, 12'h01C, 12'h032, 12'h240, 12'h00A, 12'h010,
		12'h020, 12'h034, 12'h040, 12'h0C8, 12'h0D0, 12'h0D8, 12'h100, 12'h120, 12'h140,
		12'h2C0, 12'h2F0, 12'h300, 12'h340};
	logic [11:0] hi [20] = '{12'h009, 12'h00D, 12'h01F, 12'h033, 12'h27F, 12'h00B, 12'h017,
		12'h02F, 12'h03F, 12'h06F, 12'h0CF, 12'h0D7, 12'h0DF, 12'h113, 12'h12F, 12'h17F,
		12'h2EF, 12'h2F7, 12'h327, 12'h367};
	int bn [20] = '{0, 0, 0, 0, 0, 1, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14};
	// Reserved edges
	logic [11:0] rs [15] = '{12'h00E, 12'h018, 12'h030, 12'h070, 12'h0C7, 12'h0E0, 12'h114,
		12'h13F, 12'h180, 12'h280, 12'h2BF, 12'h2F8, 12'h328, 12'h368, 12'h7FF};
	// Memory accesses: address, select, page, offset
	logic [22:0] ma [5] = '{23'h100400, 23'h101FFF, 23'h7FC005, 23'h0FD000, 23'h0FF123};
	logic [2:0] ms [5] = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h2};
	logic [8:0] mp [5] = '{9'h001, 9'h007, 9'h00F, 9'h000, 9'h002};
	logic [13:0] mo [5] = '{14'h0000, 14'h03FF, 14'h0005, 14'h0000, 14'h0123};
	// Clock at 40 MHz
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	pad_bus_master u_mst (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	pad_decoder #(.ID_MAJOR_FAMILY(4'h5), .ID_MINOR_FAMILY(6'h0A), .ID_MAJOR_MASK(2'h1),
		.ID_MINOR_MASK(4'h3), .VERSION_WORD(16'h1234)) u_dut (.core_clk(core_clk), .rst(rst),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .mod_sel(mod_sel), .mod_wr(mod_wr), .mod_rd(mod_rd),
		.mod_addr(mod_addr), .mod_wdata(mod_wdata), .mem_sel(mem_sel), .mem_page(mem_page),
		.mem_off(mem_off), .illegal_rst(illegal_rst));
	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Counts and verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		end_sim;
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 20; i++) begin
			u_mst.wr(23'(lo[i]), 8'hA5);
			chk("sel lo", 32'h1 << bn[i], 32'(mod_sel));
			chk("mod_wr", 32'h1, 32'(mod_wr));
			chk("mod_wdata", 32'hA5, 32'(mod_wdata));
			u_mst.rd(23'(hi[i]), d);
			chk("sel hi", 32'h1 << bn[i], 32'(mod_sel));
			chk("mod_addr", 32'(hi[i]), 32'(mod_addr));
			chk("mod_rd", 32'h1, 32'(mod_rd));
		end
		$display("test windows done");
		for (int i = 0; i < 15; i++) begin
			u_mst.wr(23'(rs[i]), 8'h5A);
			chk("rsv wr", 32'h0, {mod_sel, mod_wr, illegal_rst});
			u_mst.rd(23'(rs[i]), d);
			chk("rsv rd", 32'h0, {d, mod_sel, illegal_rst});
		end
		$display("test reserved done");
		u_mst.rd(23'h00001A, d);
		chk("id high", 32'(PID[15:8]), 32'(d));
		u_mst.wr(23'h00001A, 8'h00);
		u_mst.rd(23'h00001A, d);
		chk("id kept", 32'(PID[15:8]), 32'(d));
		u_mst.rd(23'h00001B, d);
		chk("id low", 32'(PID[7:0]), 32'(d));
		u_mst.rd(23'h4000E8, d);
		chk("ver high", 32'h12, 32'(d));
		u_mst.rd(23'h4000E9, d);
		chk("ver low", 32'h34, 32'(d));
		u_mst.rd(23'h000C10, d);
		chk("undef sel", 32'h0, 32'(mod_sel));
		u_mst.wr(23'h000800, 8'h11);
		chk("illegal", 32'h1, {mod_sel, illegal_rst});
		u_mst.rd(23'h130000, d);
		chk("illegal df", 32'h1, {mem_sel, illegal_rst});
		$display("test id and illegal done");
		for (int i = 0; i < 5; i++) begin
			u_mst.rd(ma[i], d);
			chk("mem", {ms[i], mp[i], mo[i], 1'b1}, {mem_sel, mem_page, mem_off, mod_rd});
		end
		$display("test memory done");
		// Mid-run reset clears every held output, then access works again
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk("reset addr", 32'h0, {mod_addr, mem_page});
		chk("reset off", 32'h0, {mem_off, mod_wdata});
		u_mst.rd(23'h00001B, d);
		chk("id after reset", 32'(PID[7:0]), 32'(d));
		$display("test reset done");
		end_sim;
	end
endmodule
`default_nettype wire
